// >>> pss_pkg.sv
`default_nettype none
package pss_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_SLEEP2   = 8'h20;
	localparam logic [7:0] OFS_STATUS   = 8'h24;
	localparam logic [7:0] OFS_CONV     = 8'h2C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h50;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h54;

	// ==========================================================
	// Field positions
	localparam int unsigned POS_LOG2      = 16;
	localparam int unsigned POS_TILE_OFF  = 14;
	localparam int unsigned POS_ANA_PFM   = 9;
	localparam int unsigned POS_CORE_PFM  = 8;
	localparam int unsigned POS_IO_EN     = 5;
	localparam int unsigned POS_PLL_EN    = 4;
	localparam int unsigned POS_ANA_EN    = 1;
	localparam int unsigned POS_CORE_EN   = 0;
	localparam int unsigned POS_STATE     = 16;
	localparam int unsigned POS_PREV      = 24;
	localparam int unsigned POS_PG_LEVEL  = 24;
	localparam int unsigned POS_ERR_CLR   = 16;
	localparam int unsigned POS_ANA_ILIM  = 13;
	localparam int unsigned POS_ANA_CLK   = 8;
	localparam int unsigned POS_CORE_ILIM = 5;
	localparam int unsigned POS_CORE_CLK  = 0;
	localparam int unsigned LOG2_W        = 5;

	// ==========================================================
	// Masks and values after reset
	localparam logic [31:0] S2_WMASK    = 32'h001F_4331;
	localparam logic [31:0] S2_RO_ONES  = 32'h0000_0002;
	localparam logic [31:0] S2_RESET    = 32'h0010_0002;
	localparam logic [31:0] CONV_WMASK  = 32'h0301_6363;
	localparam logic [31:0] CONV_RESET  = 32'h0200_0101;
	localparam logic [3:0]  PREV_RESET  = 4'h2;
	localparam logic [2:0]  IRQ_RESET   = 3'h0;
	localparam int unsigned IRQ_W       = 3;
	localparam int unsigned IRQ_ASLEEP  = 0;
	localparam int unsigned IRQ_AWAKE   = 1;
	localparam int unsigned IRQ_CONV    = 2;

	// ==========================================================
	// Types
	typedef enum logic [7:0] {
		PSS_ST_RESET  = 8'h01,
		PSS_ST_ASLEEP = 8'h02,
		PSS_ST_WAKE1  = 8'h04,
		PSS_ST_WAKE2  = 8'h08,
		PSS_ST_AWAIT  = 8'h10,
		PSS_ST_AWAKE  = 8'h20,
		PSS_ST_SLEEP1 = 8'h40,
		PSS_ST_SLEEP2 = 8'h80
	} pss_state_type;

	typedef struct packed {
		logic io;
		logic pll;
		logic ana;
		logic core;
	} pss_supply_type;

	typedef struct packed {
		logic           tile_off;
		logic           ana_pfm;
		logic           core_pfm;
		pss_supply_type en;
	} pss_cfg_type;

	typedef struct packed {
		logic [1:0] pg_level;
		logic       err_clear;
		logic [1:0] ana_ilim;
		logic [1:0] ana_clk;
		logic [1:0] core_ilim;
		logic [1:0] core_clk;
	} pss_conv_type;

	// ==========================================================
	// Helpers
	function automatic pss_cfg_type pss_cfg_of(input logic [31:0] w);
		pss_cfg_type c;
		c.tile_off = w[POS_TILE_OFF];
		c.ana_pfm  = w[POS_ANA_PFM];
		c.core_pfm = w[POS_CORE_PFM];
		c.en       = {w[POS_IO_EN], w[POS_PLL_EN], w[POS_ANA_EN], w[POS_CORE_EN]};
		return c;
	endfunction

	function automatic logic [31:0] pss_cfg_word(input pss_cfg_type c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[POS_TILE_OFF] = c.tile_off;
		w[POS_ANA_PFM]  = c.ana_pfm;
		w[POS_CORE_PFM] = c.core_pfm;
		w[POS_IO_EN]    = c.en.io;
		w[POS_PLL_EN]   = c.en.pll;
		w[POS_ANA_EN]   = c.en.ana;
		w[POS_CORE_EN]  = c.en.core;
		return w;
	endfunction

	function automatic logic [2:0] pss_state_code(input pss_state_type s);
		case (s)
			PSS_ST_RESET:  return 3'h0;
			PSS_ST_ASLEEP: return 3'h1;
			PSS_ST_WAKE1:  return 3'h2;
			PSS_ST_WAKE2:  return 3'h3;
			PSS_ST_AWAIT:  return 3'h4;
			PSS_ST_AWAKE:  return 3'h5;
			PSS_ST_SLEEP1: return 3'h6;
			PSS_ST_SLEEP2: return 3'h7;
			default:       return 3'h0;
		endcase
	endfunction

endpackage
`default_nettype wire

// >>> pss_dwell_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pss_dwell_timer #(
	parameter int unsigned CNT_W = 32
) (
	input  wire logic                       clk,      // System clock
	input  wire logic                       nrst,     // Async reset, active low
	input  wire logic                       ce,       // Clock enable
	input  wire logic                       restart,  // Phase entry, clears count
	input  wire logic [pss_pkg::LOG2_W-1:0] log2,     // Dwell exponent
	output logic      [CNT_W-1:0]           elapsed,  // Cycles since entry, held at limit
	output logic                            done      // Dwell expired
);
	// ==========================================================
	// Limit decode
	logic [CNT_W-1:0] limit;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	// Last cycle index of a 2^N long phase
	assign limit   = (CNT_W'(1) << log2) - CNT_W'(1);
	assign done    = (cnt_r >= limit);
	assign elapsed = cnt_r;
	// Saturate so a long wait on power good cannot wrap round
	assign cnt_nxt = restart ? '0 : (done ? cnt_r : cnt_r + CNT_W'(1));

	// ==========================================================
	// Counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> pss_sequencer.sv
// Contract
// - Sleep phase two applies its register settings
// - Sleep phase two lasts two-power-N cycles
// - Bit fourteen gates the tile clock off
// - Bits nine, eight pick converter modulation
// - Supply enables from bits five, four, one, zero
// - Status bits eighteen:sixteen show sequencer state
// - Status flags supplies enabled in previous state
// - Status low bits mirror applied settings
// - Converter field picks power-good threshold
// - Bit sixteen clears errors, not self-clearing
// - Field fourteen:thirteen sets analogue current limit
// - Field nine:eight sets analogue switching clock
// - Field six:five sets core current limit
// - Field one:zero sets core switching clock
// - Advance after dwell only when supplies good
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer #(
	parameter int unsigned CNT_W = 32
) (
	input  wire logic                       clk,           // 125 MHz system clock
	input  wire logic                       nrst,          // Async reset, active low
	input  wire logic                       ce,            // Clock enable, freezes all state
	input  wire logic [7:0]                 addr,          // Register byte address
	input  wire logic [31:0]                wdata,         // Write data
	input  wire logic                       wr,            // Write strobe
	input  wire logic                       rd,            // Read strobe
	output logic      [31:0]                rdata,         // Read data, cycle after rd
	input  wire logic                       sleep_req_pin, // Request to go to sleep
	input  wire logic                       wake_req_pin,  // Wake event
	input  wire logic [3:0]                 good_pin,      // Power good: io, pll, ana, core
	input  wire logic [1:0]                 conv_err_pin,  // Converter error flags
	input  wire pss_pkg::pss_cfg_type       ext_cfg,       // Settings for other states
	input  wire logic [pss_pkg::LOG2_W-1:0] ext_log2,      // Dwell exponent, other states
	output pss_pkg::pss_state_type          state_o,       // Current sequencer state
	output pss_pkg::pss_cfg_type            applied_o,     // Applied supply settings
	output pss_pkg::pss_conv_type           conv_o,        // Converter control fields
	output logic                            irq            // Level interrupt
);
	// ==========================================================
	// Pin synchronisers
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;

	// Pins come from the analogue side, two stages before use
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else if (ce) begin
			sync1_r <= {sleep_req_pin, wake_req_pin, good_pin, conv_err_pin};
			sync2_r <= sync1_r;
		end
	end

	logic                    sleep_s;
	logic                    wake_s;
	pss_pkg::pss_supply_type good_s;
	logic [1:0]              err_s;

	assign sleep_s = sync2_r[7];
	assign wake_s  = sync2_r[6];
	assign good_s  = sync2_r[5:2];
	assign err_s   = sync2_r[1:0];

	// ==========================================================
	// Register decode
	logic wr_s2;
	logic wr_conv;
	logic wr_istat;
	logic wr_imask;

	assign wr_s2    = ce && wr && (addr == pss_pkg::OFS_SLEEP2);
	assign wr_conv  = ce && wr && (addr == pss_pkg::OFS_CONV);
	assign wr_istat = ce && wr && (addr == pss_pkg::OFS_IRQ_STAT);
	assign wr_imask = ce && wr && (addr == pss_pkg::OFS_IRQ_MASK);

	// ==========================================================
	// Software registers
	logic [31:0] s2_r;
	logic [31:0] s2_nxt;
	logic [31:0] conv_r;
	logic [31:0] conv_nxt;

	// Masked merge: read-only and reserved bits keep their value
	assign s2_nxt   = (s2_r & ~pss_pkg::S2_WMASK) | (wdata & pss_pkg::S2_WMASK)
	                | pss_pkg::S2_RO_ONES;
	assign conv_nxt = (conv_r & ~pss_pkg::CONV_WMASK) | (wdata & pss_pkg::CONV_WMASK);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s2_r   <= pss_pkg::S2_RESET;
			conv_r <= pss_pkg::CONV_RESET;
		end else begin
			if (wr_s2) begin
				s2_r <= s2_nxt;
			end
			if (wr_conv) begin
				conv_r <= conv_nxt;
			end
		end
	end

	// Converter fields straight from the register
	assign conv_o.pg_level  = conv_r[pss_pkg::POS_PG_LEVEL +: 2];
	assign conv_o.err_clear = conv_r[pss_pkg::POS_ERR_CLR];
	assign conv_o.ana_ilim  = conv_r[pss_pkg::POS_ANA_ILIM +: 2];
	assign conv_o.ana_clk   = conv_r[pss_pkg::POS_ANA_CLK +: 2];
	assign conv_o.core_ilim = conv_r[pss_pkg::POS_CORE_ILIM +: 2];
	assign conv_o.core_clk  = conv_r[pss_pkg::POS_CORE_CLK +: 2];

	// ==========================================================
	// Sequencer state machine
	pss_pkg::pss_state_type  state_r;
	pss_pkg::pss_state_type  state_nxt;
	pss_pkg::pss_cfg_type    applied_r;
	pss_pkg::pss_cfg_type    applied_nxt;
	pss_pkg::pss_cfg_type    s2_cfg;
	pss_pkg::pss_supply_type prev_r;
	logic                    changing;
	logic                    pg_ok;
	logic                    tmr_done;
	logic [CNT_W-1:0]        tmr_elapsed;
	logic [pss_pkg::LOG2_W-1:0] dwell_log2;

	assign s2_cfg     = pss_pkg::pss_cfg_of(s2_r);
	// Every enabled supply must report good before a timed or await phase ends
	assign pg_ok      = &(~applied_r.en | good_s);
	assign dwell_log2 = (state_r == pss_pkg::PSS_ST_SLEEP2) ?
	                    s2_r[pss_pkg::POS_LOG2 +: pss_pkg::LOG2_W] : ext_log2;
	assign changing   = (state_nxt != state_r);

	// Next state; timed phases wait for dwell and power good
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pss_pkg::PSS_ST_RESET: begin
				state_nxt = pss_pkg::PSS_ST_WAKE1;
			end
			pss_pkg::PSS_ST_WAKE1: begin
				if (tmr_done && pg_ok) begin
					state_nxt = pss_pkg::PSS_ST_WAKE2;
				end
			end
			pss_pkg::PSS_ST_WAKE2: begin
				if (tmr_done && pg_ok) begin
					state_nxt = pss_pkg::PSS_ST_AWAIT;
				end
			end
			pss_pkg::PSS_ST_AWAIT: begin
				if (pg_ok) begin
					state_nxt = pss_pkg::PSS_ST_AWAKE;
				end
			end
			pss_pkg::PSS_ST_AWAKE: begin
				if (sleep_s) begin
					state_nxt = pss_pkg::PSS_ST_SLEEP1;
				end
			end
			pss_pkg::PSS_ST_SLEEP1: begin
				if (tmr_done && pg_ok) begin
					state_nxt = pss_pkg::PSS_ST_SLEEP2;
				end
			end
			pss_pkg::PSS_ST_SLEEP2: begin
				if (tmr_done && pg_ok) begin
					state_nxt = pss_pkg::PSS_ST_ASLEEP;
				end
			end
			pss_pkg::PSS_ST_ASLEEP: begin
				if (wake_s) begin
					state_nxt = pss_pkg::PSS_ST_WAKE1;
				end
			end
			default: begin
				state_nxt = pss_pkg::PSS_ST_RESET;
			end
		endcase
	end

	// Settings follow the state being entered, so they land with it
	assign applied_nxt = (state_nxt == pss_pkg::PSS_ST_SLEEP2) ? s2_cfg : ext_cfg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= pss_pkg::PSS_ST_RESET;
			applied_r <= '0;
			prev_r    <= pss_pkg::PREV_RESET;
		end else if (ce) begin
			state_r   <= state_nxt;
			applied_r <= applied_nxt;
			if (changing) begin
				prev_r <= applied_r.en;
			end
		end
	end

	// Dwell counter restarts on every state entry
	pss_dwell_timer #(
		.CNT_W   (CNT_W)
	) u_dwell (
		.clk     (clk),
		.nrst    (nrst),
		.ce      (ce),
		.restart (changing),
		.log2    (dwell_log2),
		.elapsed (tmr_elapsed),
		.done    (tmr_done)
	);

	assign state_o   = state_r;
	assign applied_o = applied_r;

	// ==========================================================
	// Interrupt status and mask
	logic [pss_pkg::IRQ_W-1:0] irq_stat_r;
	logic [pss_pkg::IRQ_W-1:0] irq_mask_r;
	logic [pss_pkg::IRQ_W-1:0] irq_set;
	logic [pss_pkg::IRQ_W-1:0] irq_clr;

	assign irq_set[pss_pkg::IRQ_ASLEEP] = changing && (state_nxt == pss_pkg::PSS_ST_ASLEEP);
	assign irq_set[pss_pkg::IRQ_AWAKE]  = changing && (state_nxt == pss_pkg::PSS_ST_AWAKE);
	assign irq_set[pss_pkg::IRQ_CONV]   = |err_s;
	assign irq_clr = wr_istat ? wdata[pss_pkg::IRQ_W-1:0] : '0;
	assign irq     = |(irq_stat_r & irq_mask_r);

	// Set beats a clear in the same cycle, no event is lost
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_r <= pss_pkg::IRQ_RESET;
			irq_mask_r <= pss_pkg::IRQ_RESET;
		end else if (ce) begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
			if (wr_imask) begin
				irq_mask_r <= wdata[pss_pkg::IRQ_W-1:0];
			end
		end
	end

	// ==========================================================
	// Read path
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic [31:0] rdata_r;

	assign status_word = (pss_pkg::pss_cfg_word({3'b000, prev_r}) << pss_pkg::POS_PREV)
	                   | (32'(pss_pkg::pss_state_code(state_r)) << pss_pkg::POS_STATE)
	                   | pss_pkg::pss_cfg_word(applied_r);
	// Unmapped addresses read zero
	assign rd_word = (addr == pss_pkg::OFS_SLEEP2)   ? s2_r :
	                 (addr == pss_pkg::OFS_STATUS)   ? status_word :
	                 (addr == pss_pkg::OFS_CONV)     ? conv_r :
	                 (addr == pss_pkg::OFS_IRQ_STAT) ? 32'(irq_stat_r) :
	                 (addr == pss_pkg::OFS_IRQ_MASK) ? 32'(irq_mask_r) : 32'h0000_0000;

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= 32'h0000_0000;
		end else if (ce) begin
			rdata_r <= rd ? rd_word : 32'h0000_0000;
		end
	end

	assign rdata = rdata_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s2_settled;
		(state_r == pss_pkg::PSS_ST_SLEEP2) && $stable(s2_r) && $past(ce);
	endsequence

	sequence status_read;
		ce && rd && (addr == pss_pkg::OFS_STATUS);
	endsequence

	sequence leave_timed;
		ce && changing && (state_r inside {pss_pkg::PSS_ST_WAKE1, pss_pkg::PSS_ST_WAKE2,
		                   pss_pkg::PSS_ST_SLEEP1, pss_pkg::PSS_ST_SLEEP2});
	endsequence

	sleep2_cfg_a: assert property (s2_settled |-> applied_r == s2_cfg)
		else $error("sleep phase two settings not applied");

	dwell_len_a: assert property (
		(ce && changing && state_r == pss_pkg::PSS_ST_SLEEP2) |->
		tmr_elapsed >= ((CNT_W'(1) << s2_r[pss_pkg::POS_LOG2 +: pss_pkg::LOG2_W]) - CNT_W'(1)))
		else $error("sleep phase two left before its dwell");

	tile_gate_a: assert property (s2_settled |-> applied_o.tile_off == s2_r[pss_pkg::POS_TILE_OFF])
		else $error("tile clock gate differs from register");

	mod_sel_a: assert property (s2_settled |-> {applied_o.ana_pfm, applied_o.core_pfm} ==
		s2_r[pss_pkg::POS_CORE_PFM +: 2])
		else $error("modulation select differs from register");

	supply_en_a: assert property (s2_settled |-> applied_o.en.ana &&
		applied_o.en.io == s2_r[pss_pkg::POS_IO_EN])
		else $error("sleep phase two supply enables wrong");

	state_code_a: assert property (status_read |=>
		rdata[pss_pkg::POS_STATE +: 3] == pss_pkg::pss_state_code($past(state_r)))
		else $error("status state field wrong");

	prev_en_a: assert property ((ce && changing) |=> prev_r == $past(applied_r.en))
		else $error("previous supply flags not captured");

	status_mirror_a: assert property (status_read |=>
		rdata[14:0] == pss_pkg::pss_cfg_word($past(applied_r)) && rdata[31:30] == 2'b00)
		else $error("status mirror bits wrong");

	pg_thresh_a: assert property ((wr_conv && !rd) |=>
		conv_o.pg_level == $past(wdata[pss_pkg::POS_PG_LEVEL +: 2]))
		else $error("power good threshold not taken");

	err_hold_a: assert property ((conv_o.err_clear && !wr_conv) |=> conv_o.err_clear)
		else $error("error clear bit cleared itself");

	pg_gate_a: assert property (leave_timed |-> tmr_done &&
		(applied_r.en & ~good_s) == 4'h0)
		else $error("timed phase left without power good");

	ro_bits_a: assert property ((ce && rd && addr == pss_pkg::OFS_SLEEP2) |=>
		rdata[1] && (rdata & ~(pss_pkg::S2_WMASK | pss_pkg::S2_RO_ONES)) == 32'h0000_0000)
		else $error("sleep phase two read-only bits wrong");

	irq_set_a: assert property ((ce && irq_set != '0) |=> (irq_stat_r & $past(irq_set)) ==
		$past(irq_set))
		else $error("interrupt event lost");

	// Read data stand one cycle only, an idle bus reads zero
	rdata_idle_a: assert property ((ce && !rd) |=> rdata == 32'h0000_0000)
		else $error("read data outside answer cycle");

	irq_clear_a: assert property ((wr_istat && (irq_set & wdata[pss_pkg::IRQ_W-1:0]) == '0) |=>
		(irq_stat_r & $past(wdata[pss_pkg::IRQ_W-1:0])) == '0)
		else $error("interrupt status not cleared");
endmodule
`default_nettype wire

// >>> pss_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module pss_supply_model (
	input  wire logic       clk,     // System clock
	input  wire logic       nrst,    // Async reset, active low
	input  wire logic [3:0] en,      // Enables io, pll, ana, core
	input  wire logic       slow,    // Long ramp instead of short
	input  wire logic       drop,    // Brown-out, restarts every ramp
	input  wire logic [1:0] err_set, // Inject converter faults
	input  wire logic       err_clr, // Error clear from the device
	output logic      [3:0] good,    // Power good per supply
	output logic      [1:0] err      // Latched converter errors
);
	// ==========================================================
	// Rail ramps
	logic      [5:0] ramp_r [4];
	wire logic [5:0] ramp_len = slow ? 6'h28 : 6'h02;

	// A disabled rail is off, so it never claims to be good
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 4; i++) begin
				ramp_r[i] <= 6'h00;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!en[i] || drop) begin
					ramp_r[i] <= 6'h00;
				end else if (ramp_r[i] != 6'h3F) begin
					ramp_r[i] <= ramp_r[i] + 6'h01;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			good[i] = en[i] && (ramp_r[i] >= ramp_len);
		end
	end

	// Errors stay latched; a clear held high also blocks new ones
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err <= 2'h0;
		end else begin
			err <= err_clr ? 2'h0 : (err | err_set);
		end
	end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
	logic                   clk, nrst, wr, rd, sleep_req, wake_req, slow, drop, irq;
	logic [7:0]             addr;
	logic [31:0]            wdata, rdata, rv, rw;
	logic [3:0]             good;
	logic [1:0]             err, err_set;
	pss_pkg::pss_cfg_type   ext_cfg, applied;
	pss_pkg::pss_state_type state;
	pss_pkg::pss_conv_type  conv;
	int                     err_count, total_checks, n;

	pss_sequencer #(.CNT_W(32)) i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep_req_pin(sleep_req),
		.wake_req_pin(wake_req), .good_pin(good), .conv_err_pin(err), .ext_cfg(ext_cfg),
		.ext_log2(5'h02), .state_o(state), .applied_o(applied), .conv_o(conv), .irq(irq));

	pss_supply_model i_supply (.clk(clk), .nrst(nrst), .en(applied.en), .slow(slow),
		.drop(drop), .err_set(err_set), .err_clr(conv.err_clear), .good(good), .err(err));

	// ==========================================================
	// Clock and bus tasks
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wait_st(input pss_pkg::pss_state_type s);
		n = 0;
		while (state !== s && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (state !== s) begin
			err_count++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, state, s);
			test_done();
		end
	endtask

	// Counts the cycles spent in a state, optionally checking settings
	task automatic dwell(input pss_pkg::pss_state_type s, input pss_pkg::pss_cfg_type c,
		input logic chk);
		wait_st(s);
		n = 0;
		while (state === s && n < 400) begin
			if (chk) `CHK(applied, c)
			@(posedge clk);
			#1;
			n++;
		end
		// A phase that never ends is a hang, not a long dwell
		if (state === s) begin
			err_count++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, n, 400);
			test_done();
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		{wr, rd, sleep_req, wake_req, slow, drop} = 6'h00;
		{addr, wdata, err_set} = 42'h0;
		ext_cfg = 7'h0F;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd32(8'h20, rv);
		`CHK(rv, 32'h0010_0002)
		rd32(8'h2C, rv);
		`CHK(rv, 32'h0200_0101)
		`CHK(conv, 11'h411)
		rd32(8'h30, rv);
		`CHK(rv, 32'h0000_0000)
		wr32(8'h20, 32'hFFFF_FFFF);
		rd32(8'h20, rv);
		`CHK(rv, 32'h001F_4333)
		wr32(8'h20, 32'h0000_0000);
		rd32(8'h20, rv);
		`CHK(rv, 32'h0000_0002)
		$display("register reset and access done");
		// Every code of each converter field, error clear toggling
		for (int v = 0; v < 4; v++) begin
			rv = {6'h0, v[1:0], 7'h0, v[0], 1'b0, v[1:0], 3'h0, v[1:0], 1'b0, v[1:0], 3'h0, v[1:0]};
			wr32(8'h2C, rv);
			`CHK(conv, {v[1:0], v[0], v[1:0], v[1:0], v[1:0], v[1:0]})
			rd32(8'h2C, rw);
			`CHK(rw, rv)
		end
		wr32(8'h2C, 32'hFFFF_FFFF);
		rd32(8'h2C, rv);
		`CHK(rv, 32'h0301_6363)
		wr32(8'h2C, 32'h0200_0101);
		$display("converter fields done");
		wait_st(pss_pkg::PSS_ST_AWAKE);
		rd32(8'h24, rv);
		`CHK(rv, 32'h3305_0033)
		wr32(8'h24, 32'hFFFF_FFFF);
		rd32(8'h24, rv);
		`CHK(rv, 32'h3305_0033)
		// Sleep entry with N of two and mixed settings
		wr32(8'h20, 32'h0002_4223);
		wr32(8'h50, 32'h0000_0007);
		wr32(8'h54, 32'h0000_0001);
		`CHK(irq, 1'b0)
		sleep_req <= 1'b1;
		wait_st(pss_pkg::PSS_ST_SLEEP1);
		sleep_req <= 1'b0;
		dwell(pss_pkg::PSS_ST_SLEEP2, 7'h6B, 1'b1);
		`CHK(n, 4)
		`CHK(state, pss_pkg::PSS_ST_ASLEEP)
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b1)
		rd32(8'h24, rv);
		`CHK(rv, 32'h2301_0033)
		rd32(8'h50, rv);
		`CHK(rv, 32'h0000_0001)
		wr32(8'h50, 32'h0000_0001);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		$display("sleep sequence done");
		// Wake with slow supplies after a brown-out
		slow <= 1'b1;
		drop <= 1'b1;
		@(posedge clk);
		drop <= 1'b0;
		wake_req <= 1'b1;
		dwell(pss_pkg::PSS_ST_WAKE1, 7'h0F, 1'b0);
		wake_req <= 1'b0;
		`CHK(n >= 20, 1'b1)
		wait_st(pss_pkg::PSS_ST_AWAKE);
		slow <= 1'b0;
		$display("slow wake done");
		// Error flags stay until cleared by the converter control
		err_set <= 2'h1;
		@(posedge clk);
		err_set <= 2'h0;
		wr32(8'h54, 32'h0000_0004);
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b1)
		wr32(8'h50, 32'h0000_0004);
		rd32(8'h50, rv);
		`CHK(rv[2], 1'b1)
		wr32(8'h2C, 32'h0201_0101);
		`CHK(conv.err_clear, 1'b1)
		repeat (4) @(posedge clk);
		`CHK(conv.err_clear, 1'b1)
		wr32(8'h2C, 32'h0200_0101);
		repeat (4) @(posedge clk);
		wr32(8'h50, 32'h0000_0004);
		rd32(8'h50, rv);
		`CHK(rv[2], 1'b0)
		`CHK(irq, 1'b0)
		$display("error clear done");
		test_done();
	end
endmodule
`default_nettype wire
